// *** hw/adcrc_pkg.sv ***
// Functional notes
// - upper result: high bits, others zero
// - lower result refreshed every unlocked conversion end
// - ten-bit: upper read locks until lower read
// - locked results completing are discarded
// - eight-bit mode: no read lock
// - low-power bit selects reduced power
// - divider codes divide by 1,2,4,8
// - select bit: 1 bus, 0 alternate
// - mode: 8-bit sw, 10-bit sw, 10-bit hw
// - reset returns eight-bit mode
// - result rounded to selected width
// - sample 3.5 or 23.5 converter cycles; code samples 4 or 24 ticks
// - async enable: async source, runs in stop
// - async clear: select bit rules, stop halts
// - done flag: set at end, cleared by access
// - status write aborts, restarts (hw mode: only arms) unless all ones
// - continuous stops on reset, stop without async, writes
// - all-ones channel powers off, isolates input
//
// shared constants and carriers of the converter control block.
// assumes the analog core reports a raw code with one guard bit.
package adcrc_pkg;

	// register addresses on the plain port
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_UPPER = 4'h1;
	localparam logic [3:0] ADDR_LOWER = 4'h2;
	localparam logic [3:0] ADDR_CLOCK = 4'h3;

	// reset values
	localparam logic [7:0] CLOCK_RESET = 8'h00;
	localparam logic [4:0] CHANNEL_OFF = 5'h1f;

	// mode codes
	localparam logic [1:0] MODE_8_SW = 2'h0;
	localparam logic [1:0] MODE_10_SW = 2'h1;
	localparam logic [1:0] MODE_10_HW = 2'h3;

	// sample lengths in converter half cycles, rounded up to whole ticks
	localparam int SAMPLE_SHORT_HALVES = 7;
	localparam int SAMPLE_LONG_HALVES = 47;
	localparam logic [4:0] SAMPLE_SHORT_TICKS = 5'((SAMPLE_SHORT_HALVES + 1) / 2);
	localparam logic [4:0] SAMPLE_LONG_TICKS = 5'((SAMPLE_LONG_HALVES + 1) / 2);

	// conversion phases
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_SAMPLE = 2'b01,
		PH_CONVERT = 2'b10
	} adcrc_phase_t;

	// clock configuration register layout
	typedef struct packed {
		logic low_power;
		logic [1:0] clock_divide_field;
		logic input_clock_select;
		logic [1:0] mode;
		logic long_sample_select;
		logic async_clock_enable;
	} adcrc_clk_cfg_t;

	// register bus request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} adcrc_bus_req_t;

	// controls toward the analog core
	typedef struct packed {
		logic power_up;
		logic isolate;
		logic low_power;
		logic ten_bit;
		logic sample;
		logic convert;
		logic converter_clock;
		logic [4:0] channel_select;
	} adcrc_core_ctrl_t;

	// answer from the analog core
	typedef struct packed {
		logic done;
		logic [10:0] raw;
	} adcrc_core_resp_t;

	// whole state of the control block
	typedef struct packed {
		adcrc_phase_t phase;
		logic [2:0] div_count;
		logic [4:0] phase_count;
		logic conversion_done_flag;
		logic continuous_convert;
		logic [4:0] channel_select;
		adcrc_clk_cfg_t cfg;
		logic lock;
		logic armed;
		logic run_cont;
		logic [1:0] result_upper;
		logic [7:0] result_lower;
		logic [7:0] rdata;
		logic [1:0] alt_sync;
		logic alt_last;
		logic [1:0] async_sync;
		logic async_last;
		logic [1:0] trig_sync;
		logic trig_last;
	} adcrc_state_t;

endpackage : adcrc_pkg

// *** hw/adcrc_top.sv ***
// converter control: result registers with read lock, clock register,
// clock divider and conversion sequencer for the analog core.
// assumes the core pulses done one cycle with its raw code, and that
// the clock pins are slow against CLOCK.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module adcrc_top (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RESET_N,
	// register port
	input wire adcrc_pkg::adcrc_bus_req_t BUS_REQ,
	output logic [7:0] BUS_RDATA,
	// analog core
	output var adcrc_pkg::adcrc_core_ctrl_t CORE_CTRL,
	input wire adcrc_pkg::adcrc_core_resp_t CORE_RESP,
	// clock sources and system
	input wire logic ALT_CLK_PIN,
	input wire logic ASYNC_CLK_PIN,
	output logic ASYNC_OSC_EN,
	input wire logic HW_TRIGGER_PIN,
	input wire logic STOP_MODE
);

	////////////////////////////////////////////////////////////////////
	// helpers

	// mask of the divider count for a divide code
	function automatic logic [2:0] div_mask(input logic [1:0] code);
		div_mask = 3'((4'h1 << code) - 4'h1);
	endfunction : div_mask

	// mode decode used by lock, rounding and core
	function automatic logic is_ten_bit(input logic [1:0] mode);
		is_ten_bit = (mode == adcrc_pkg::MODE_10_SW) ||
			(mode == adcrc_pkg::MODE_10_HW);
	endfunction : is_ten_bit

	// round the raw code with guard bit, saturating at full scale
	function automatic logic [9:0] round_raw(input logic [10:0] raw,
		input logic ten);
		logic [10:0] s10;
		logic [8:0] s8;
		s10 = {1'b0, raw[10:1]} + {10'h000, raw[0]};
		s8 = {1'b0, raw[10:3]} + {8'h00, raw[2]};
		if (ten) begin
			round_raw = s10[10] ? 10'h3ff : s10[9:0];
		end else begin
			round_raw = {2'h0, (s8[8] ? 8'hff : s8[7:0])};
		end
	endfunction : round_raw

	////////////////////////////////////////////////////////////////////
	// state

	adcrc_pkg::adcrc_state_t st; // registered state
	adcrc_pkg::adcrc_state_t next_st; // next state

	// decoded strobes
	logic sc_wr; // status register written
	logic cfg_wr; // clock register written
	logic upper_rd; // upper result read
	logic lower_rd; // lower result read
	logic ten; // ten-bit mode active
	logic hw_mode; // hardware trigger mode
	logic src_tick; // selected input clock edge
	logic tick; // converter clock enable
	logic stop_halt; // stop without async clock
	logic trig_edge; // hardware trigger rising edge
	logic [4:0] sample_ticks; // sample length in ticks
	logic [9:0] rounded; // rounded result
	logic busy; // conversion in progress

	assign sc_wr = BUS_REQ.wr && (BUS_REQ.addr == adcrc_pkg::ADDR_STATUS);
	assign cfg_wr = BUS_REQ.wr && (BUS_REQ.addr == adcrc_pkg::ADDR_CLOCK);
	assign upper_rd = BUS_REQ.rd && (BUS_REQ.addr == adcrc_pkg::ADDR_UPPER);
	assign lower_rd = BUS_REQ.rd && (BUS_REQ.addr == adcrc_pkg::ADDR_LOWER);
	assign ten = is_ten_bit(st.cfg.mode);
	assign hw_mode = (st.cfg.mode == adcrc_pkg::MODE_10_HW);
	assign busy = (st.phase != adcrc_pkg::PH_IDLE);
	assign rounded = round_raw(CORE_RESP.raw, ten);
	assign trig_edge = st.trig_sync[1] && !st.trig_last;
	// async clock halts nothing in stop; otherwise stop kills all work
	assign stop_halt = STOP_MODE && !st.cfg.async_clock_enable;
	assign sample_ticks = st.cfg.long_sample_select ?
		adcrc_pkg::SAMPLE_LONG_TICKS :
		adcrc_pkg::SAMPLE_SHORT_TICKS;

	// pick the input clock: async pin, bus clock or alternate pin
	always_comb begin
		if (st.cfg.async_clock_enable) begin
			src_tick = st.async_sync[1] && !st.async_last;
		end else if (st.cfg.input_clock_select) begin
			src_tick = 1'b1;
		end else begin
			src_tick = st.alt_sync[1] && !st.alt_last;
		end
	end

	// converter clock fires on the last input edge of each period
	assign tick = src_tick && (st.div_count == div_mask(
		st.cfg.clock_divide_field));

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_st = st;
		// pin synchronisers; first stage feeds only the second
		next_st.alt_sync = {st.alt_sync[0], ALT_CLK_PIN};
		next_st.alt_last = st.alt_sync[1];
		next_st.async_sync = {st.async_sync[0], ASYNC_CLK_PIN};
		next_st.async_last = st.async_sync[1];
		next_st.trig_sync = {st.trig_sync[0], HW_TRIGGER_PIN};
		next_st.trig_last = st.trig_sync[1];

		// divider count, restarted when the setting changes
		if (cfg_wr) begin
			next_st.div_count = 3'h0;
		end else if (tick) begin
			next_st.div_count = 3'h0;
		end else if (src_tick) begin
			next_st.div_count = st.div_count + 3'h1;
		end

		// sequencer
		unique case (st.phase)
			adcrc_pkg::PH_IDLE: begin
				// hardware trigger starts an armed conversion
				if (hw_mode && st.armed && trig_edge) begin
					next_st.phase = adcrc_pkg::PH_SAMPLE;
					next_st.phase_count = 5'h00;
				end
			end
			adcrc_pkg::PH_SAMPLE: begin
				if (tick) begin
					if (st.phase_count == sample_ticks - 5'h01) begin
						next_st.phase = adcrc_pkg::PH_CONVERT;
					end
					next_st.phase_count = st.phase_count + 5'h01;
				end
			end
			adcrc_pkg::PH_CONVERT: begin
				if (CORE_RESP.done) begin
					// continuous software mode goes straight on
					if (st.run_cont && !hw_mode) begin
						next_st.phase = adcrc_pkg::PH_SAMPLE;
					end else begin
						next_st.phase = adcrc_pkg::PH_IDLE;
					end
					next_st.phase_count = 5'h00;
				end
			end
			default: begin
				// illegal code falls back to idle
				next_st.phase = adcrc_pkg::PH_IDLE;
			end
		endcase

		// results: store unless the ten-bit lock holds them
		if (CORE_RESP.done && (st.phase == adcrc_pkg::PH_CONVERT)) begin
			if (!(ten && st.lock) || lower_rd) begin
				next_st.result_upper = ten ? rounded[9:8] : 2'h0;
				next_st.result_lower = rounded[7:0];
			end
		end

		// read lock: upper read arms it, lower read releases it
		if (!ten) begin
			next_st.lock = 1'b0;
		end else if (lower_rd) begin
			next_st.lock = 1'b0;
		end else if (upper_rd) begin
			next_st.lock = 1'b1;
		end

		// done flag; a completing conversion beats the clear
		if (CORE_RESP.done && (st.phase == adcrc_pkg::PH_CONVERT)) begin
			next_st.conversion_done_flag = 1'b1;
		end else if (sc_wr || lower_rd) begin
			next_st.conversion_done_flag = 1'b0;
		end

		// clock register write halts continuous work
		if (cfg_wr) begin
			next_st.cfg = adcrc_pkg::adcrc_clk_cfg_t'(BUS_REQ.wdata);
			next_st.run_cont = 1'b0;
			next_st.phase = adcrc_pkg::PH_IDLE;
		end

		// status write aborts; a real channel restarts the conversion, or only arms the trigger in hardware mode
		if (sc_wr) begin
			next_st.continuous_convert = BUS_REQ.wdata[5];
			next_st.channel_select = BUS_REQ.wdata[4:0];
			next_st.phase = adcrc_pkg::PH_IDLE;
			next_st.phase_count = 5'h00;
			next_st.run_cont = 1'b0;
			next_st.armed = 1'b0;
			if (BUS_REQ.wdata[4:0] != adcrc_pkg::CHANNEL_OFF) begin
				next_st.run_cont = BUS_REQ.wdata[5];
				if (hw_mode) begin
					next_st.armed = 1'b1;
				end else begin
					next_st.phase = adcrc_pkg::PH_SAMPLE;
				end
			end
		end

		// stop without the async clock ends everything until rewritten
		if (stop_halt) begin
			next_st.phase = adcrc_pkg::PH_IDLE;
			next_st.run_cont = 1'b0;
			next_st.armed = 1'b0;
		end

		// read data, one cycle after the strobe; unmapped reads zero
		next_st.rdata = 8'h00;
		if (BUS_REQ.rd) begin
			unique case (BUS_REQ.addr)
				adcrc_pkg::ADDR_STATUS: next_st.rdata = {
					st.conversion_done_flag, 1'b0,
					st.continuous_convert, st.channel_select};
				adcrc_pkg::ADDR_UPPER:
					next_st.rdata = {6'h00, st.result_upper};
				adcrc_pkg::ADDR_LOWER: next_st.rdata = st.result_lower;
				adcrc_pkg::ADDR_CLOCK: next_st.rdata = st.cfg;
				default: next_st.rdata = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers

	// synchronous reset; clock register zero gives eight-bit mode
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			st <= '0;
			st.cfg <= adcrc_pkg::adcrc_clk_cfg_t'(adcrc_pkg::CLOCK_RESET);
			st.channel_select <= adcrc_pkg::CHANNEL_OFF;
			st.phase <= adcrc_pkg::PH_IDLE;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	assign BUS_RDATA = st.rdata;
	// async generator runs only while a conversion is under way
	assign ASYNC_OSC_EN = st.cfg.async_clock_enable && busy;
	// core controls in one process, so the carrier has a single driver
	always_comb begin
		CORE_CTRL.power_up = busy;
		CORE_CTRL.isolate =
			(st.channel_select == adcrc_pkg::CHANNEL_OFF);
		CORE_CTRL.low_power = st.cfg.low_power;
		CORE_CTRL.ten_bit = ten;
		CORE_CTRL.sample = (st.phase == adcrc_pkg::PH_SAMPLE);
		CORE_CTRL.convert = (st.phase == adcrc_pkg::PH_CONVERT);
		CORE_CTRL.converter_clock = tick && busy;
		CORE_CTRL.channel_select = st.channel_select;
	end

	////////////////////////////////////////////////////////////////////
	// checks

	property p_upper_zero;
		@(posedge CLOCK) disable iff (!RESET_N)
		upper_rd |=> (BUS_RDATA[7:2] == 6'h00);
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("upper result high bits not zero");

	property p_lower_update;
		@(posedge CLOCK) disable iff (!RESET_N)
		(CORE_RESP.done && CORE_CTRL.convert && !st.lock && !cfg_wr)
		|=> (st.result_lower == $past(rounded[7:0]));
	endproperty
	a_lower_update: assert property (p_lower_update)
		else $error("lower result not refreshed");

	property p_lock_hold;
		@(posedge CLOCK) disable iff (!RESET_N)
		(ten && st.lock && !lower_rd && CORE_RESP.done)
		|=> $stable(st.result_lower) && $stable(st.result_upper);
	endproperty
	a_lock_hold: assert property (p_lock_hold)
		else $error("locked result overwritten");

	property p_lock_set;
		@(posedge CLOCK) disable iff (!RESET_N)
		(upper_rd && ten && !cfg_wr) ##1 (!lower_rd && !cfg_wr)[*3]
		|-> st.lock;
	endproperty
	a_lock_set: assert property (p_lock_set)
		else $error("upper read did not lock");

	property p_no_lock_8bit;
		@(posedge CLOCK) disable iff (!RESET_N)
		(!ten && !cfg_wr) |=> !st.lock;
	endproperty
	a_no_lock_8bit: assert property (p_no_lock_8bit)
		else $error("lock held in eight-bit mode");

	property p_divide8;
		@(posedge CLOCK) disable iff (!RESET_N)
		(tick && st.cfg.input_clock_select && !st.cfg.async_clock_enable
			&& st.cfg.clock_divide_field == 2'h3 && !cfg_wr)
		##1 (!cfg_wr)[*7]
		|=> tick;
	endproperty
	a_divide8: assert property (p_divide8)
		else $error("divide by eight period wrong");

	property p_flag_set;
		@(posedge CLOCK) disable iff (!RESET_N)
		(CORE_RESP.done && CORE_CTRL.convert) |=> st.conversion_done_flag;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("done flag not set");

	property p_flag_clear;
		@(posedge CLOCK) disable iff (!RESET_N)
		(lower_rd && !CORE_RESP.done) |=> !st.conversion_done_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("done flag not cleared");

	property p_start;
		@(posedge CLOCK) disable iff (!RESET_N)
		(sc_wr && !hw_mode && !STOP_MODE
			&& BUS_REQ.wdata[4:0] != adcrc_pkg::CHANNEL_OFF)
		|=> CORE_CTRL.sample ##0 (st.phase_count == 5'h00);
	endproperty
	a_start: assert property (p_start)
		else $error("status write did not restart");

	property p_stop_halt;
		@(posedge CLOCK) disable iff (!RESET_N)
		stop_halt |=> !busy && !st.run_cont;
	endproperty
	a_stop_halt: assert property (p_stop_halt)
		else $error("conversion survived stop");

	property p_off;
		@(posedge CLOCK) disable iff (!RESET_N)
		(sc_wr && BUS_REQ.wdata[4:0] == adcrc_pkg::CHANNEL_OFF)
		|=> !busy && CORE_CTRL.isolate && !CORE_CTRL.power_up;
	endproperty
	a_off: assert property (p_off)
		else $error("off channel did not power down");

	property p_reset_cfg;
		@(posedge CLOCK)
		!RESET_N |=> (st.cfg == adcrc_pkg::CLOCK_RESET);
	endproperty
	a_reset_cfg: assert property (p_reset_cfg)
		else $error("clock register not reset");

endmodule : adcrc_top

`default_nettype wire

// *** bench/adcrc_testbench.sv ***
// self-checking bench for the converter control block.
// assumes adcrc_pkg is compiled first; the bench plays software,
// the analog core and the clock pins itself.
`timescale 1ns/100ps
`default_nettype none

module testbench;
	// design pins
	logic CLOCK = 1'b0;
	logic RESET_N = 1'b0;
	adcrc_pkg::adcrc_bus_req_t req = '0;
	logic [7:0] rdata;
	adcrc_pkg::adcrc_core_ctrl_t ctl;
	adcrc_pkg::adcrc_core_resp_t resp = '0;
	logic alt = 1'b0;
	logic asy = 1'b0;
	logic osc;
	logic trig = 1'b0;
	logic stop = 1'b0;
	// bench state
	int fail_count = 0;
	int checks_done = 0;
	int seed = 32'h8bda;
	int tick = 0;
	int n, g;
	bit ok;
	logic [7:0] d, e;
	logic [9:0] v;
	logic [10:0] r1, r2;

	adcrc_top dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .BUS_REQ(req),
		.BUS_RDATA(rdata), .CORE_CTRL(ctl), .CORE_RESP(resp),
		.ALT_CLK_PIN(alt), .ASYNC_CLK_PIN(asy), .ASYNC_OSC_EN(osc),
		.HW_TRIGGER_PIN(trig), .STOP_MODE(stop));

	////////////////////////////////////////////////////////////////////////
	// 8 ns clock
	initial begin
		forever #4 CLOCK = ~CLOCK;
	end

	// alt pin rises every 6 cycles; async only while its oscillator runs
	always @(posedge CLOCK) begin
		tick <= tick + 1;
		if (tick % 3 == 2) begin
			alt <= ~alt;
		end
		if (osc === 1'b1 && tick[0]) begin
			asy <= ~asy;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// expected rounding: guard bit adds half, full scale saturates
	function automatic logic [9:0] r10(input logic [10:0] r);
		return (r[10:1] == 10'h3ff) ? 10'h3ff : r[10:1] + 10'(r[0]);
	endfunction : r10

	function automatic logic [7:0] r8(input logic [10:0] r);
		return (r[10:3] == 8'hff) ? 8'hff : r[10:3] + 8'(r[2]);
	endfunction : r8

	// one comparison
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// verdict, reached from the main sequence or the watchdog
	task automatic conclude();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude

	task automatic cyc(input int k);
		repeat (k) @(posedge CLOCK);
	endtask : cyc

	// bus write: one strobe cycle, returns at the taking edge
	task automatic wr(input logic [3:0] a, input logic [7:0] x);
		@(posedge CLOCK);
		req <= {2'b01, a, x};
		@(posedge CLOCK);
		req <= '0;
	endtask : wr

	// bus read: data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] x);
		@(posedge CLOCK);
		req <= {2'b10, a, 8'h00};
		@(posedge CLOCK);
		req <= '0;
		#1 x = rdata;
	endtask : rd

	// ticks seen in the sampling phase, and the gap between the first two
	task automatic meas(output int cnt, output int gap);
		int last;
		cnt = 0;
		gap = 0;
		last = 0;
		for (int k = 0; k < 400; k++) begin
			#1;
			if (ctl.sample !== 1'b1 && cnt > 0) break;
			if (ctl.sample === 1'b1 && ctl.converter_clock === 1'b1) begin
				if (cnt == 1) gap = k - last;
				last = k;
				cnt++;
			end
			@(posedge CLOCK);
		end
	endtask : meas

	// core side: wait for the approximation phase, pulse done once
	task automatic fin(input logic [10:0] raw);
		for (int k = 0; k < 4000 && ctl.convert !== 1'b1; k++) begin
			@(posedge CLOCK);
			#1;
		end
		chk(ctl.convert, 1'b1);
		@(posedge CLOCK);
		resp <= {1'b1, raw};
		@(posedge CLOCK);
		resp <= '0;
	endtask : fin

	// bounded look for the converter powering up
	task automatic busy(input int lim, output bit b);
		b = 1'b0;
		for (int k = 0; k < lim && !b; k++) begin
			@(posedge CLOCK);
			#1;
			b = (ctl.power_up === 1'b1);
		end
	endtask : busy

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		cyc(8);
		RESET_N <= 1'b1;
		rd(3, e);
		chk(e, 8'h00);
		rd(1, e);
		chk(e, 8'h00);
		chk(ctl.isolate, 1'b1);
		rd(4'h9, e);
		chk(e, 8'h00);
		$display("test reset done");
		// every mode code with random other fields
		for (int m = 0; m < 4; m++) begin
			d = $random(seed);
			d[3:2] = m[1:0];
			wr(3, d);
			rd(3, e);
			chk(e, d);
			chk(ctl.low_power, d[7]);
			chk(ctl.ten_bit, d[2]);
		end
		$display("test clock register done");
		// eight-bit: upper reads zero and never locks
		wr(3, 8'h10);
		for (int i = 0; i < 6; i++) begin
			r1 = $random(seed);
			r2 = (i == 0) ? 11'h7ff : (i == 1) ? 11'h003 : $random(seed);
			wr(0, 8'h03); // only real channels are picked in this loop
			meas(n, g);
			fin(r1);
			#1 chk(ctl.power_up, 1'b0);
			chk(16'(ctl.channel_select), 16'h0003);
			rd(0, e);
			chk(e[7], 1'b1);
			rd(1, e);
			chk(e, 8'h00);
			wr(0, 8'h03);
			meas(n, g);
			fin(r2);
			rd(2, e);
			chk(e, r8(r2));
			rd(0, e);
			chk(e, 8'h03);
		end
		$display("test eight-bit done");
		// ten-bit: upper read locks, next result is discarded
		wr(3, 8'h14);
		for (int i = 0; i < 4; i++) begin
			r1 = (i == 0) ? 11'h7ff : (i == 1) ? 11'h001 : $random(seed);
			r2 = $random(seed);
			v = r10(r1);
			wr(0, 8'h02);
			meas(n, g);
			fin(r1);
			rd(1, e);
			chk(e, {6'h00, v[9:8]});
			wr(0, 8'h02);
			meas(n, g);
			fin(r2);
			rd(2, e);
			chk(e, v[7:0]);
			v = r10(r2);
			wr(0, 8'h02);
			meas(n, g);
			fin(r2);
			rd(1, e);
			chk(e, {6'h00, v[9:8]});
			rd(2, e);
			chk(e, v[7:0]);
		end
		$display("test ten-bit done");
		// divider codes, sample lengths and the alternate source
		for (int c = 0; c < 4; c++) begin
			wr(3, {1'b0, c[1:0], 5'h10});
			wr(0, 8'h01);
			meas(n, g);
			fin(11'h000);
			chk(16'(n), 16'd4);
			chk(16'(g), 16'(1 << c));
		end
		wr(3, 8'h12);
		wr(0, 8'h01);
		meas(n, g);
		fin(11'h000);
		chk(16'(n), 16'd24);
		wr(3, 8'h00);
		wr(0, 8'h01);
		meas(n, g);
		fin(11'h000);
		chk(16'(g), 16'd6);
		$display("test clocking done");
		// async source keeps converting in stop mode
		wr(3, 8'h01);
		stop <= 1'b1;
		wr(0, 8'h01);
		meas(n, g);
		chk(osc, 1'b1);
		chk(16'(g), 16'd4);
		fin(11'h000);
		cyc(2);
		#1 chk(osc, 1'b0);
		rd(0, e);
		chk(e[7], 1'b1);
		// stop without async aborts
		wr(3, 8'h10);
		stop <= 1'b0;
		wr(0, 8'h01);
		cyc(2);
		stop <= 1'b1;
		cyc(3);
		#1 chk(ctl.power_up, 1'b0);
		@(posedge CLOCK);
		stop <= 1'b0;
		// all-ones channel powers off
		wr(0, 8'h01);
		cyc(2);
		wr(0, 8'h1f);
		#1 chk(ctl.power_up, 1'b0);
		chk(ctl.isolate, 1'b1);
		$display("test stop and abort done");
		// continuous runs on until the clock register is written
		wr(0, 8'h21);
		meas(n, g);
		fin($random(seed));
		busy(4, ok);
		chk(ok, 1'b1);
		wr(3, 8'h10);
		#1 chk(ctl.power_up, 1'b0);
		busy(40, ok);
		chk(ok, 1'b0);
		$display("test continuous done");
		// hardware trigger mode waits for the pin
		wr(3, 8'h1c);
		wr(0, 8'h01);
		busy(20, ok);
		chk(ok, 1'b0);
		@(posedge CLOCK);
		trig <= 1'b1;
		busy(10, ok);
		chk(ok, 1'b1);
		r1 = $random(seed);
		v = r10(r1);
		fin(r1);
		trig <= 1'b0;
		rd(1, e);
		chk(e, {6'h00, v[9:8]});
		rd(2, e);
		chk(e, v[7:0]);
		$display("test trigger done");
		// mid-run reset ends continuous work and restores eight-bit mode
		wr(3, 8'h14);
		wr(0, 8'h21);
		cyc(3);
		RESET_N <= 1'b0;
		cyc(2);
		RESET_N <= 1'b1;
		#1 chk(ctl.power_up, 1'b0);
		chk(ctl.ten_bit, 1'b0);
		chk(ctl.isolate, 1'b1);
		rd(3, e);
		chk(e, 8'h00);
		busy(40, ok);
		chk(ok, 1'b0);
		$display("test second reset done");
		conclude();
	end

	// watchdog: the whole run needs far fewer than 50000 cycles
	initial begin
		#400000;
		fail_count++;
		conclude();
	end
endmodule : testbench

`default_nettype wire
